// ### tpc_timer_pair.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defs.svh"
// Overview of operation
// - and-select 0: each timer drives its own pwm and pulse pins
// - and-select 1: timer b pins carry timer a AND timer b
// - and-select 1: timer a pins carry no output and sit high
// - cascade 0 gives two 8-bit timers, 1 one 16-bit timer
// - run bit 0 stops and clears its counter, 1 starts counting
// - in cascade the timer b run bit runs the whole pair
// - stop mode entry clears both run bits and halts both timers
// - pair control reads zero in bits 7 to 4
// - and-select and cascade writes ignored while any run bit is 1
// - write starting runs from idle also updates and-select and cascade
// - cascade takes its source clock from timer b clock select
// - low-frequency clock not oscillating gives no ticks, timer stays still
// - normal/idle: event modes use pin, others internal, 8/16-bit either
// - slow/sleep: only codes 000, 001, 111 usable, fs/16, fs/8, fs/4
// - clock gate 0 cuts the basic clock to both counters
// - clock gate 1 supplies the basic clock to both counters
// - clock gate resets to 0
// - mode register writes ignored while that timer runs
// - counter match raises the request, clears counter, keeps counting
module tpc_timer_pair #(
  parameter int PRE_W = `TPC_PRE_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TPC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system state
  input wire tpc_pkg::tpc_power_type powerMode,
  input wire logic stopEntry,
  input wire logic lowFreqDivSel,
  input wire logic lowFreqClk,
  input wire logic lowFreqOscOk,
  // event inputs
  input wire logic eventInputPinA,
  input wire logic eventInputPinB,
  // timer outputs
  output logic timerAPwmPin,
  output logic timerAPulsePin,
  output logic timerBPwmPin,
  output logic timerBPulsePin,
  output logic timerAMatchIrq,
  output logic timerBMatchIrq
);
  import tpc_pkg::*;

  localparam int S_LFC = 0;
  localparam int S_EVA = 1;
  localparam int S_EVB = 2;
  localparam int S_OSC = 3;

  logic [1:0] rstSync_r;
  logic [3:0] sync0_r;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] level_r;
  logic [PRE_W-1:0] pre_r;
  logic [3:0] lfCnt_r;
  logic [3:0] ctrl_r;
  logic [7:0] pgate_r;
  logic [7:0] modeA_r;
  logic [7:0] modeB_r;
  logic [7:0] cmpA_r;
  logic [7:0] cmpB_r;
  logic [7:0] cntA_r;
  logic [7:0] cntB_r;
  logic [1:0] stat_r;
  logic ffA_r;
  logic ffB_r;

  // release of the reset through two flip-flops
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      rstSync_r <= 2'b00;
    else
      rstSync_r <= {rstSync_r[0], 1'b1};
  wire rstnSync = rstSync_r[1];

  // all ones in the low k bits of the prescaler
  function automatic logic divTick(input logic [PRE_W-1:0] p,
                                   input int k);
    logic r;
    r = 1'b1;
    for (int i = 0; i < PRE_W; i++)
      if (i < k)
        r = r & p[i];
    return r;
  endfunction

  // prescaler exponent of each clock code
  function automatic int divExp(input logic [2:0] sel);
    case (sel)
      3'h0: return 11;
      3'h1: return 10;
      3'h2: return 8;
      3'h3: return 6;
      3'h4: return 4;
      3'h5: return 2;
      3'h6: return 1;
      default: return 0;
    endcase
  endfunction

  // internal source tick for a clock code
  function automatic logic intTick(input logic [2:0] sel,
                                   input logic slow,
                                   input logic dv9,
                                   input logic [PRE_W-1:0] p,
                                   input logic [2:0] fs);
    logic g;
    g = divTick(p, divExp(sel));
    case (sel)
      3'h0: return (slow | dv9) ? fs[0] : g;
      3'h1: return (slow | dv9) ? fs[1] : g;
      3'h7: return slow ? fs[2] : g;
      default: return slow ? 1'b0 : g;
    endcase
  endfunction

  // source of a timer: pin in event modes, else internal
  function automatic logic pickTick(input logic [7:0] mode,
                                    input logic casc,
                                    input logic pin,
                                    input logic it);
    if (!mode[`TPC_EIN_BIT])
      return it;
    else if (!mode[`TPC_TCM_HI] || casc)
      return pin;
    else
      return 1'b0;
  endfunction

  // a pin level counts once the second and third stages agree
  wire [3:0] agree = ~(sync1_r ^ sync2_r);
  wire [3:0] levelNxt = (level_r & ~agree) | (sync2_r & agree);
  wire [3:0] fallEv = level_r & ~levelNxt;
  wire lfRise = ~level_r[S_LFC] & levelNxt[S_LFC];

  // three-stage pin synchronisers; second and third must agree
  always_ff @(posedge sys_clk or negedge rstnSync)
    if (!rstnSync)
    begin
      sync0_r <= 4'h0;
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      level_r <= 4'h0;
    end
    else
    begin
      sync0_r <= {lowFreqOscOk, eventInputPinB, eventInputPinA, lowFreqClk};
      sync1_r <= sync0_r;
      sync2_r <= sync1_r;
      level_r <= levelNxt;
    end

  // clock gate and power mode
  wire gate = pgate_r[`TPC_GATE_BIT];
  wire slow = (powerMode == TPC_SLOW) | (powerMode == TPC_SLEEP);
  wire lfOk = lfRise & level_r[S_OSC];
  wire [2:0] fsTick = {lfOk & (&lfCnt_r[1:0]),
                       lfOk & (&lfCnt_r[2:0]),
                       lfOk & (&lfCnt_r)};

  // gear prescaler and low-frequency divider, stopped with the gate
  always_ff @(posedge sys_clk or negedge rstnSync)
    if (!rstnSync)
    begin
      pre_r <= '0;
      lfCnt_r <= 4'h0;
    end
    else
    begin
      pre_r <= gate ? pre_r + 1'b1 : pre_r;
      lfCnt_r <= (gate & lfRise) ? lfCnt_r + 4'h1 : lfCnt_r;
    end

  // control and run state
  wire runA = ctrl_r[`TPC_RUNA_BIT];
  wire runB = ctrl_r[`TPC_RUNB_BIT];
  wire casc = ctrl_r[`TPC_CASC_BIT];
  wire andSel = ctrl_r[`TPC_AND_BIT];
  wire runEffA = casc ? runB : runA;
  wire lockCfg = runA | runB;

  // source clock selection; cascade uses timer b code
  wire [7:0] srcModeA = casc ? modeB_r : modeA_r;
  wire itA = intTick(srcModeA[`TPC_TCK_HI:`TPC_TCK_LO], slow,
                     lowFreqDivSel, pre_r, fsTick);
  wire itB = intTick(modeB_r[`TPC_TCK_HI:`TPC_TCK_LO], slow,
                     lowFreqDivSel, pre_r, fsTick);
  wire tickA = pickTick(srcModeA, casc, fallEv[S_EVA], itA);
  wire tickB = pickTick(modeB_r, casc, fallEv[S_EVB], itB);

  // counting steps and matches
  wire stepA = gate & runEffA & tickA;
  wire stepB = gate & runB & ~casc & tickB;
  wire matchA = cntA_r == cmpA_r;
  wire matchB = cntB_r == cmpB_r;
  wire match16 = {cntB_r, cntA_r} == {cmpB_r, cmpA_r};
  wire evA = stepA & (casc ? match16 : matchA);
  wire evB = stepB & matchB;
  wire carryA = cntA_r == 8'hff;

  // counter next values; a stopped timer holds zero
  wire [7:0] incA = cntA_r + 8'h01;
  wire [7:0] incB = cntB_r + 8'h01;
  wire [7:0] cntA_nxt = !runEffA ? 8'h00 :
                        !stepA ? cntA_r :
                        evA ? 8'h00 : incA;
  wire [7:0] cntB_nxt = !runB ? 8'h00 :
                        (casc & stepA) ? (evA ? 8'h00 :
                          (carryA ? incB : cntB_r)) :
                        !stepB ? cntB_r :
                        evB ? 8'h00 : incB;

  // timer results; timer and event modes hold the pins high
  wire resA = modeA_r[`TPC_TCM_HI] ? ffA_r : 1'b1;
  wire resB = modeB_r[`TPC_TCM_HI] ? ffB_r : 1'b1;
  wire pinA = andSel ? 1'b1 : resA;
  wire pinB = andSel ? (resA & resB) : resB;

  // apb decode
  wire access = psel & penable;
  wire selCtrl = paddr == `TPC_ADDR_CTRL;
  wire selPgate = paddr == `TPC_ADDR_PGATE;
  wire selModeA = paddr == `TPC_ADDR_MODEA;
  wire selModeB = paddr == `TPC_ADDR_MODEB;
  wire selCmpA = paddr == `TPC_ADDR_CMPA;
  wire selCmpB = paddr == `TPC_ADDR_CMPB;
  wire selCount = paddr == `TPC_ADDR_COUNT;
  wire selStat = paddr == `TPC_ADDR_STAT;
  wire hit = selCtrl | selPgate | selModeA | selModeB | selCmpA |
             selCmpB | selCount | selStat;
  wire wrEn = access & pready & pwrite & hit;
  wire rdCap = access & ~pready & ~pwrite;

  // read data; upper control bits read zero
  wire [31:0] rdMux =
    ({32{selCtrl}} & {28'h0, ctrl_r}) |
    ({32{selPgate}} & {24'h0, pgate_r}) |
    ({32{selModeA}} & {24'h0, modeA_r}) |
    ({32{selModeB}} & {24'h0, modeB_r}) |
    ({32{selCmpA}} & {24'h0, cmpA_r}) |
    ({32{selCmpB}} & {24'h0, cmpB_r}) |
    ({32{selCount}} & {16'h0, cntB_r, cntA_r}) |
    ({32{selStat}} & {30'h0, stat_r});

  // control next value; config locked while running, stop entry wins
  wire ctrlWr = wrEn & selCtrl;
  wire [1:0] runWr = ctrlWr ? pwdata[1:0] : ctrl_r[1:0];
  wire [1:0] runNxt = stopEntry ? 2'b00 : runWr;
  wire [1:0] cfgNxt = (ctrlWr & ~lockCfg) ? pwdata[3:2] :
                      ctrl_r[3:2];
  wire [3:0] ctrl_nxt = {cfgNxt, runNxt};

  // sticky match flags, set beats write-one-to-clear
  wire [1:0] statClr = (wrEn & selStat) ? pwdata[1:0] : 2'b00;
  wire [1:0] stat_nxt = (stat_r & ~statClr) | {evB, evA};

  // register bank
  always_ff @(posedge sys_clk or negedge rstnSync)
    if (!rstnSync)
    begin
      ctrl_r <= `TPC_CTRL_RST;
      pgate_r <= `TPC_PGATE_RST;
      modeA_r <= `TPC_MODE_RST;
      modeB_r <= `TPC_MODE_RST;
      cmpA_r <= `TPC_CMP_RST;
      cmpB_r <= `TPC_CMP_RST;
      stat_r <= 2'b00;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      stat_r <= stat_nxt;
      if (wrEn & selPgate)
        pgate_r <= pwdata[7:0];
      if (wrEn & selModeA & ~runEffA)
        modeA_r <= pwdata[7:0];
      if (wrEn & selModeB & ~runB)
        modeB_r <= pwdata[7:0];
      if (wrEn & selCmpA)
        cmpA_r <= pwdata[7:0];
      if (wrEn & selCmpB)
        cmpB_r <= pwdata[7:0];
    end

  // counters and timer flip-flops
  always_ff @(posedge sys_clk or negedge rstnSync)
    if (!rstnSync)
    begin
      cntA_r <= 8'h00;
      cntB_r <= 8'h00;
      ffA_r <= 1'b0;
      ffB_r <= 1'b0;
    end
    else
    begin
      cntA_r <= cntA_nxt;
      cntB_r <= cntB_nxt;
      ffA_r <= !runEffA ? modeA_r[`TPC_TFF_BIT] :
               ffA_r ^ (evA & ~casc);
      ffB_r <= !runB ? modeB_r[`TPC_TFF_BIT] :
               ffB_r ^ (casc ? evA : evB);
    end

  // bus answer with one wait state, and registered pins
  always_ff @(posedge sys_clk or negedge rstnSync)
    if (!rstnSync)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      timerAPwmPin <= 1'b1;
      timerAPulsePin <= 1'b1;
      timerBPwmPin <= 1'b1;
      timerBPulsePin <= 1'b1;
      timerAMatchIrq <= 1'b0;
      timerBMatchIrq <= 1'b0;
    end
    else
    begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~hit;
      if (rdCap)
        prdata <= rdMux;
      timerAPwmPin <= pinA;
      timerAPulsePin <= pinA;
      timerBPwmPin <= pinB;
      timerBPulsePin <= pinB;
      timerAMatchIrq <= evA;
      timerBMatchIrq <= evB;
    end
endmodule
`default_nettype wire

// ### tpc_defs.svh
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH
// byte addresses on the register bus
`define TPC_ADDR_W 12
`define TPC_ADDR_CTRL 12'h02c
`define TPC_ADDR_PGATE 12'hf74
`define TPC_ADDR_MODEA 12'h030
`define TPC_ADDR_MODEB 12'h034
`define TPC_ADDR_CMPA 12'h038
`define TPC_ADDR_CMPB 12'h03c
`define TPC_ADDR_COUNT 12'h040
`define TPC_ADDR_STAT 12'h044
// pair control fields
`define TPC_RUNA_BIT 0
`define TPC_RUNB_BIT 1
`define TPC_CASC_BIT 2
`define TPC_AND_BIT 3
// power gate field
`define TPC_GATE_BIT 4
// mode register fields
`define TPC_TFF_BIT 7
`define TPC_TCK_HI 5
`define TPC_TCK_LO 3
`define TPC_EIN_BIT 2
`define TPC_TCM_HI 1
// reset values
`define TPC_CTRL_RST 4'h0
`define TPC_PGATE_RST 8'h00
`define TPC_MODE_RST 8'h00
`define TPC_CMP_RST 8'hff
// gear clock prescaler width
`define TPC_PRE_W 11
`endif

// ### tpc_pkg.sv
`default_nettype none
package tpc_pkg;
  // chip power modes seen by the timer pair
  typedef enum logic [1:0] {
    TPC_NORMAL,
    TPC_IDLE,
    TPC_SLOW,
    TPC_SLEEP
  } tpc_power_type;
endpackage
`default_nettype wire

// ### tpc_timer_pair_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defs.svh"
module tpc_timer_pair_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TPC_ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic timerAPwmPin,
  input wire logic timerAPulsePin,
  input wire logic timerBPwmPin,
  input wire logic timerBPulsePin
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // offsets that answer without error
  wire inWin = paddr >= `TPC_ADDR_MODEA && paddr <= `TPC_ADDR_STAT;
  wire mapped = paddr == `TPC_ADDR_CTRL || paddr == `TPC_ADDR_PGATE ||
    (inWin && paddr[1:0] == 2'h0);
  wire rdCtrl = pready && !pwrite && paddr == `TPC_ADDR_CTRL;
  // bus handshake and register map
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_one_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("wait state count");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_decode: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr decode");
  a_ctrl_upper: assert property (rdCtrl |-> prdata[31:4] == 28'h0)
    else $error("control upper bits");
  a_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("prdata moved");
  // output pin pairs
  a_pins_a: assert property (timerAPwmPin == timerAPulsePin)
    else $error("timer a pins differ");
  a_pins_b: assert property (timerBPwmPin == timerBPulsePin)
    else $error("timer b pins differ");
  c_error: cover property (pready && pslverr);
  c_read: cover property (rdCtrl);
  c_pin_low: cover property ($fell(timerBPwmPin));
endmodule
bind tpc_timer_pair tpc_timer_pair_chk u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timerAPwmPin(timerAPwmPin),
  .timerAPulsePin(timerAPulsePin), .timerBPwmPin(timerBPwmPin),
  .timerBPulsePin(timerBPulsePin));
`default_nettype wire

// ### tb_tpc_timer_pair.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defs.svh"
`define CHK(n, e, a) \
  begin \
    nCompared++; \
    if ((a) !== (e)) \
    begin \
      $display("unexpected %s exp %h got %h", n, e, a); \
      miscompares++; \
    end \
  end
module tb_tpc_timer_pair;
  import tpc_pkg::*;
  logic sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, ex, c, g, rs = 32'h7e091fb7;
  logic pready, pslverr, aPwm, bPwm, irqB, evA = 1, evB = 1;
  logic stopEntry = 0, fsClk = 0, fsOk = 1;
  logic [1:0] fd = 0;
  tpc_power_type powerMode = TPC_NORMAL;
  logic [31:0] q[$];
  int miscompares = 0, nCompared = 0;
  tpc_timer_pair dut (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .powerMode(powerMode),
    .stopEntry(stopEntry), .lowFreqDivSel(1'b0), .lowFreqClk(fsClk),
    .lowFreqOscOk(fsOk), .eventInputPinA(evA), .eventInputPinB(evB),
    .timerAPwmPin(aPwm), .timerAPulsePin(), .timerBPwmPin(bPwm),
    .timerBPulsePin(), .timerAMatchIrq(), .timerBMatchIrq(irqB));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  always #12.5 sys_clk = ~sys_clk;
  // random event pins and a slow clock of four cycles
  always @(posedge sys_clk)
  begin
    rs <= xs(rs);
    evA <= rs[0];
    evB <= rs[1];
    fd <= fd + 2'h1;
    fsClk <= fd[1];
  end
  // compare each read answer against the oldest note
  always @(posedge sys_clk)
  begin
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0)
    begin
      ex = q.pop_front();
      `CHK("prdata", ex, prdata)
    end
  end
  task end_sim;
    if (miscompares == 0 && nCompared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one apb transfer, then an idle cycle
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    i = 0;
    do @(posedge sys_clk); while (pready !== 1'b1 && i++ < 40);
    if (pready !== 1'b1)
    begin
      miscompares++;
      end_sim;
    end
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    apb(0, a, 0);
  endtask
  // cycles between two match pulses, 0 if none comes
  task gap(output logic [31:0] n);
    int i;
    n = 0;
    for (i = 0; i < 300 && dut.timerAMatchIrq !== 1'b1; i++)
      @(posedge sys_clk);
    if (dut.timerAMatchIrq === 1'b1)
    begin
      @(posedge sys_clk);
      for (n = 1; n < 300 && dut.timerAMatchIrq !== 1'b1; n++)
        @(posedge sys_clk);
    end
  endtask
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    miscompares++;
    end_sim;
  end
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1;
    repeat (3) @(posedge sys_clk);
    rd(`TPC_ADDR_CTRL, 0);
    rd(`TPC_ADDR_PGATE, 0);
    apb(1, `TPC_ADDR_PGATE, 32'h10);
    rd(`TPC_ADDR_PGATE, 32'h10);
    apb(1, `TPC_ADDR_CTRL, 32'hff);
    rd(`TPC_ADDR_CTRL, 32'h0f);
    apb(1, `TPC_ADDR_CTRL, 0);
    rd(`TPC_ADDR_CTRL, 32'h0c);
    apb(1, `TPC_ADDR_CTRL, 0);
    rd(`TPC_ADDR_CTRL, 0);
    for (int i = 0; i < 8; i++)
    begin
      apb(1, `TPC_ADDR_MODEA, {24'h0, i[0], 7'h02});
      apb(1, `TPC_ADDR_MODEB, {24'h0, i[1], 7'h02});
      apb(1, `TPC_ADDR_CTRL, {28'h0, i[2], 3'h0});
      @(posedge sys_clk);
      `CHK("pinA", i[2] | i[0], aPwm)
      `CHK("pinB", i[2] ? i[0] & i[1] : i[1], bPwm)
    end
    c = {27'h0, rs[4:0]} + 32'h2;
    apb(1, `TPC_ADDR_CMPA, c);
    apb(1, `TPC_ADDR_MODEA, 32'h38);
    apb(1, `TPC_ADDR_CTRL, 1);
    gap(g);
    `CHK("period", c + 1, g)
    `CHK("irqB", 1'b0, irqB)
    rd(`TPC_ADDR_STAT, 1);
    apb(1, `TPC_ADDR_MODEA, 0);
    rd(`TPC_ADDR_MODEA, 32'h38);
    apb(1, `TPC_ADDR_CTRL, 0);
    rd(`TPC_ADDR_COUNT, 0);
    apb(1, `TPC_ADDR_MODEB, 32'h38);
    apb(1, `TPC_ADDR_MODEA, 0);
    apb(1, `TPC_ADDR_CMPB, 0);
    apb(1, `TPC_ADDR_CTRL, 32'h6);
    gap(g);
    `CHK("cascade", c + 1, g)
    apb(1, `TPC_ADDR_CTRL, 32'h3);
    stopEntry <= 1;
    @(posedge sys_clk);
    stopEntry <= 0;
    rd(`TPC_ADDR_CTRL, 32'h4);
    apb(1, `TPC_ADDR_CTRL, 0);
    apb(1, `TPC_ADDR_MODEA, 32'h38);
    apb(1, `TPC_ADDR_PGATE, 0);
    apb(1, `TPC_ADDR_CTRL, 1);
    gap(g);
    `CHK("gated", 0, g)
    apb(1, `TPC_ADDR_CTRL, 0);
    apb(1, `TPC_ADDR_PGATE, 32'h10);
    powerMode <= TPC_SLOW;
    apb(1, `TPC_ADDR_MODEA, 32'h10);
    apb(1, `TPC_ADDR_CTRL, 1);
    gap(g);
    `CHK("slow010", 0, g)
    apb(1, `TPC_ADDR_CTRL, 0);
    apb(1, `TPC_ADDR_CMPA, 3);
    apb(1, `TPC_ADDR_MODEA, 32'h38);
    apb(1, `TPC_ADDR_CTRL, 1);
    gap(g);
    `CHK("slow111", 64, g)
    fsOk <= 0;
    repeat (8) @(posedge sys_clk);
    gap(g);
    `CHK("fsdead", 0, g)
    apb(1, `TPC_ADDR_CTRL, 0);
    rd(12'h100, 0);
    end_sim;
  end
endmodule
`default_nettype wire
